// ===== verilog/att_pkg.sv
// constants and types shared by the asynchronous timer block
// assumes an 8-bit i/o register port with 6-bit addresses
package att_pkg;

    // -------------------------------------------------------------------
    // register offsets on the i/o port
    // -------------------------------------------------------------------
    localparam logic [5:0] ADDR_TIMER_IRQ_MASK     = 6'h39;
    localparam logic [5:0] ADDR_TIMER_IRQ_FLAGS    = 6'h38;
    localparam logic [5:0] ADDR_TIMER_A_CONTROL    = 6'h33;
    localparam logic [5:0] ADDR_TIMER_A_COUNT      = 6'h32;
    localparam logic [5:0] ADDR_TIMER_A_COMPARE    = 6'h31;
    localparam logic [5:0] ADDR_SPECIAL_FUNCTION   = 6'h30;
    localparam logic [5:0] ADDR_TIMER_B_CONTROL    = 6'h27;
    localparam logic [5:0] ADDR_ASYNC_TIMER_STATUS = 6'h26;
    localparam logic [5:0] ADDR_TIMER_B_COUNT      = 6'h23;
    localparam logic [5:0] ADDR_TIMER_B_COMPARE    = 6'h22;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int TA_CMP_BIT       = 0;
    localparam int TA_OVF_BIT       = 1;
    localparam int TB_OVF_BIT       = 6;
    localparam int TB_CMP_BIT       = 7;
    localparam int PSR_BIT          = 0;
    localparam int ASYNC_SEL_BIT    = 3;
    localparam int CNT_BUSY_BIT     = 2;
    localparam int CMP_BUSY_BIT     = 1;
    localparam int CTRL_BUSY_BIT    = 0;
    localparam int CTRL_UPDOWN_BIT  = 6;
    localparam int CTRL_FASTPWM_BIT = 3;
    localparam int CTRL_CS_LSB      = 0;
    localparam int CTRL_CS_W        = 3;

    // -------------------------------------------------------------------
    // reset values and counts
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic [9:0] PRESCALER_RESET  = 10'h000;
    localparam logic [7:0] COUNT_TOP        = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM     = 8'h00;
    localparam int         FLAG_SYNC_CYCLES = 3;

    // clock select codes; 6 and 7 stop timer a in this block, while timer b counts on any nonzero code
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;

    typedef struct packed {
        logic [7:0] cnt;
        logic       down;
        logic       ovf;
        logic       match;
    } att_step_t;

endpackage

// ===== verilog/att_stage_if.sv
// carrier between the timer top and one staged register channel
// assumes both ends run on the system clock
`timescale 1ns/100ps

interface att_stage_if;
    logic       wr;
    logic [7:0] wdata;
    logic       async_mode;
    logic       tick;
    logic       busy;
    logic [7:0] temp;
    logic [7:0] active;
    logic       load;

    modport host  (output wr, wdata, async_mode, tick,
                   input  busy, temp, active, load);
    modport stage (input  wr, wdata, async_mode, tick,
                   output busy, temp, active, load);
endinterface

// ===== verilog/att_stage.sv
// one staged register: temporary holding copy, timer-side copy, busy flag
// assumes tick is a one-cycle pulse at each timer clock edge
`timescale 1ns/100ps

module att_stage
    import att_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = REG_RESET
) (
    input wire logic         clk,
    input wire logic         rst,
    att_stage_if.stage       sif
);
    import att_pkg::*;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] active;
        logic       busy;
        logic       load;
    } att_stage_state_t;

    att_stage_state_t s;
    att_stage_state_t next_s;

    // -------------------------------------------------------------------
    // request / acknowledge
    // -------------------------------------------------------------------
    always_comb begin
        next_s      = s;
        next_s.load = 1'b0;
        // a write while busy overwrites the holding copy; software must wait
        if (sif.wr) begin
            next_s.temp = sif.wdata;
            if (sif.async_mode) begin
                next_s.busy = 1'b1;
            end else begin
                next_s.active = sif.wdata;
                next_s.load   = 1'b1;
                next_s.busy   = 1'b0;
            end
        end else if (s.busy && sif.tick) begin
            // timer edge acknowledges the staged value
            next_s.active = s.temp;
            next_s.busy   = 1'b0;
            next_s.load   = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{temp: RESET_VAL, active: RESET_VAL, busy: 1'b0,
                   load: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign sif.busy   = s.busy;
    assign sif.temp   = s.temp;
    assign sif.active = s.active;
    assign sif.load   = s.load;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    busy_set_a: assert property (
        (sif.wr && sif.async_mode) |=> s.busy && s.temp == $past(sif.wdata))
        else $error("busy flag not raised by async write");

    sequence staged_ack;
        s.busy && !sif.wr && sif.tick;
    endsequence

    busy_clear_a: assert property (
        staged_ack |=> !s.busy && s.load && s.active == $past(s.temp))
        else $error("busy flag not released on timer edge");

    busy_hold_a: assert property (
        (s.busy && !sif.wr && !sif.tick) |=> s.busy && !s.load)
        else $error("busy flag released without acknowledge");

endmodule

// ===== verilog/att_timer.sv
// two 8-bit timers, prescaler on timer a only, async-capable timer b
// assumes an i/o register port on SYS_CLK; OSC_IN is an unsynced pin
`timescale 1ns/100ps

// Functional notes
// - a one written to the prescaler reset bit clears the timer a prescaler.
// - that bit clears itself after the reset; writing zero does nothing.
// - the prescaler reset bit always reads as zero.
// - up/down pwm sets overflow flag when counter leaves zero.
// - overflow pwm sets the overflow flag as in normal counting.
// - overflow interrupt asserts only with flag, its enable and global enable.
// - compare flag and interrupt behave like the overflow flag in all modes.
// - async select zero makes timer b count on the system clock.
// - async select one counts timer b on the oscillator pin, claiming pins.
// - async count write sets count busy until the count is loaded.
// - async compare write sets compare busy until transferred.
// - async control write sets control busy until transferred.
// - reading timer b count returns the live count.
// - reading timer b compare or control returns the holding copy.
// - upper four bits of async status read as zero.
// - async timer b flags appear three system cycles after the timer edge.
module att_timer
    import att_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       SYS_RST,
    input  wire logic [5:0] IO_ADDR,
    input  wire logic [7:0] IO_WDATA,
    input  wire logic       IO_WE,
    input  wire logic       IO_RE,
    output logic      [7:0] IO_RDATA,
    input  wire logic       GLOBAL_IRQ_EN,
    input  wire logic       OSC_IN,
    output logic            OSC_PINS_CLAIMED,
    output logic            PRESCALER_CLEAR,
    output logic            IRQ_TA_OVF,
    output logic            IRQ_TA_CMP,
    output logic            IRQ_TB_OVF,
    output logic            IRQ_TB_CMP
);
    import att_pkg::*;

    typedef struct packed {
        logic [7:0]                       irq_mask;
        logic [7:0]                       flags;
        logic [7:0]                       ta_ctrl;
        logic [7:0]                       ta_cnt;
        logic [7:0]                       ta_cmp;
        logic                             ta_down;
        logic [9:0]                       pre;
        logic                             psr_pulse;
        logic                             as_mode;
        logic [7:0]                       tb_cnt;
        logic                             tb_down;
        logic [2:0]                       osc_sync;
        logic [FLAG_SYNC_CYCLES-1:0][1:0] evt_pipe;
        logic [7:0]                       rdata;
    } att_top_state_t;

    att_top_state_t s;
    att_top_state_t next_s;

    att_stage_if cnt_if ();
    att_stage_if cmp_if ();
    att_stage_if ctl_if ();

    att_stage #(.RESET_VAL(REG_RESET)) u_cnt_stage (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .sif (cnt_if)
    );
    att_stage #(.RESET_VAL(REG_RESET)) u_cmp_stage (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .sif (cmp_if)
    );
    att_stage #(.RESET_VAL(REG_RESET)) u_ctl_stage (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .sif (ctl_if)
    );

    // -------------------------------------------------------------------
    // one counting step, shared by both timers
    // -------------------------------------------------------------------
    function automatic att_step_t timer_step(input logic [7:0] cnt,
                                             input logic       down,
                                             input logic [7:0] ctrl,
                                             input logic [7:0] cmp,
                                             input logic       tick);
        att_step_t r;
        r = '{cnt: cnt, down: down, ovf: 1'b0, match: 1'b0};
        if (tick) begin
            r.match = (cnt == cmp);
            if (ctrl[CTRL_UPDOWN_BIT]) begin
                if (!down && cnt == COUNT_TOP) begin
                    r.down = 1'b1;
                    r.cnt  = cnt - 8'h01;
                end else if (cnt == COUNT_BOTTOM) begin
                    r.down = 1'b0;
                    r.cnt  = cnt + 8'h01;
                    r.ovf  = 1'b1;
                end else begin
                    r.cnt = down ? cnt - 8'h01 : cnt + 8'h01;
                end
            end else begin
                // normal and overflow pwm wrap the same way
                r.down = 1'b0;
                r.cnt  = cnt + 8'h01;
                r.ovf  = (cnt == COUNT_TOP);
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------------
    // decode and tick sources
    // -------------------------------------------------------------------
    logic      wr_sel_flags;
    logic      psr_write;
    logic      osc_edge;
    logic      tb_src_tick;
    logic      ta_tick;
    logic      tb_tick;
    logic [2:0] ta_cs;
    logic [7:0] status_rd;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    att_step_t step_a;
    att_step_t step_b;

    assign wr_sel_flags = IO_WE && IO_ADDR == ADDR_TIMER_IRQ_FLAGS;
    assign psr_write    = IO_WE && IO_ADDR == ADDR_SPECIAL_FUNCTION
                          && IO_WDATA[PSR_BIT];
    // osc_sync[0] is read only by osc_sync[1]
    assign osc_edge     = s.osc_sync[1] && !s.osc_sync[2];
    assign tb_src_tick  = s.as_mode ? osc_edge : 1'b1;
    assign ta_cs        = s.ta_ctrl[CTRL_CS_LSB +: CTRL_CS_W];

    always_comb begin
        unique case (ta_cs)
            CS_DIV1:    ta_tick = 1'b1;
            CS_DIV8:    ta_tick = &s.pre[2:0];
            CS_DIV64:   ta_tick = &s.pre[5:0];
            CS_DIV256:  ta_tick = &s.pre[7:0];
            CS_DIV1024: ta_tick = &s.pre[9:0];
            default:    ta_tick = 1'b0;
        endcase
    end

    // timer b has no prescaler of its own here: any nonzero select counts
    assign tb_tick = tb_src_tick
                     && ctl_if.active[CTRL_CS_LSB +: CTRL_CS_W] != CS_STOP;

    assign step_a = timer_step(s.ta_cnt, s.ta_down, s.ta_ctrl, s.ta_cmp,
                               ta_tick);
    assign step_b = timer_step(s.tb_cnt, s.tb_down, ctl_if.active,
                               cmp_if.active, tb_tick);

    // staged channels for timer b
    assign cnt_if.wr         = IO_WE && IO_ADDR == ADDR_TIMER_B_COUNT;
    assign cmp_if.wr         = IO_WE && IO_ADDR == ADDR_TIMER_B_COMPARE;
    assign ctl_if.wr         = IO_WE && IO_ADDR == ADDR_TIMER_B_CONTROL;
    assign cnt_if.wdata      = IO_WDATA;
    assign cmp_if.wdata      = IO_WDATA;
    assign ctl_if.wdata      = IO_WDATA;
    assign cnt_if.async_mode = s.as_mode;
    assign cmp_if.async_mode = s.as_mode;
    assign ctl_if.async_mode = s.as_mode;
    assign cnt_if.tick       = tb_src_tick;
    assign cmp_if.tick       = tb_src_tick;
    assign ctl_if.tick       = tb_src_tick;

    assign status_rd = {4'h0, s.as_mode, cnt_if.busy, cmp_if.busy,
                        ctl_if.busy};

    // -------------------------------------------------------------------
    // flags and register state
    // -------------------------------------------------------------------
    always_comb begin
        flag_set = 8'h00;
        flag_set[TA_OVF_BIT] = step_a.ovf;
        flag_set[TA_CMP_BIT] = step_a.match;
        // async events wait out the flag synchroniser
        if (s.as_mode) begin
            flag_set[TB_OVF_BIT] = s.evt_pipe[FLAG_SYNC_CYCLES-1][1];
            flag_set[TB_CMP_BIT] = s.evt_pipe[FLAG_SYNC_CYCLES-1][0];
        end else begin
            flag_set[TB_OVF_BIT] = step_b.ovf;
            flag_set[TB_CMP_BIT] = step_b.match;
        end
        flag_clr = wr_sel_flags ? IO_WDATA : 8'h00;
    end

    always_comb begin
        next_s = s;
        next_s.osc_sync  = {s.osc_sync[1], s.osc_sync[0], OSC_IN};
        next_s.evt_pipe  = {s.evt_pipe[FLAG_SYNC_CYCLES-2:0],
                            {step_b.ovf && s.as_mode,
                             step_b.match && s.as_mode}};
        // set wins over a clear in the same cycle
        next_s.flags     = (s.flags & ~flag_clr) | flag_set;
        next_s.psr_pulse = psr_write;
        next_s.pre       = psr_write ? PRESCALER_RESET
                                     : s.pre + 10'h001;
        next_s.ta_cnt    = step_a.cnt;
        next_s.ta_down   = step_a.down;
        next_s.tb_cnt    = step_b.cnt;
        next_s.tb_down   = step_b.down;
        if (cnt_if.load) begin
            next_s.tb_cnt = cnt_if.active;
        end
        if (IO_WE) begin
            unique case (IO_ADDR)
                ADDR_TIMER_IRQ_MASK:     next_s.irq_mask = IO_WDATA;
                ADDR_TIMER_A_CONTROL:    next_s.ta_ctrl  = IO_WDATA;
                ADDR_TIMER_A_COUNT:      next_s.ta_cnt   = IO_WDATA;
                ADDR_TIMER_A_COMPARE:    next_s.ta_cmp   = IO_WDATA;
                ADDR_ASYNC_TIMER_STATUS: begin
                    next_s.as_mode = IO_WDATA[ASYNC_SEL_BIT];
                end
                default: ;
            endcase
        end
        if (IO_RE) begin
            unique case (IO_ADDR)
                ADDR_TIMER_IRQ_MASK:     next_s.rdata = s.irq_mask;
                ADDR_TIMER_IRQ_FLAGS:    next_s.rdata = s.flags;
                ADDR_TIMER_A_CONTROL:    next_s.rdata = s.ta_ctrl;
                ADDR_TIMER_A_COUNT:      next_s.rdata = s.ta_cnt;
                ADDR_TIMER_A_COMPARE:    next_s.rdata = s.ta_cmp;
                ADDR_SPECIAL_FUNCTION:   next_s.rdata = 8'h00;
                ADDR_TIMER_B_CONTROL:    next_s.rdata = ctl_if.temp;
                ADDR_ASYNC_TIMER_STATUS: next_s.rdata = status_rd;
                ADDR_TIMER_B_COUNT:      next_s.rdata = s.tb_cnt;
                ADDR_TIMER_B_COMPARE:    next_s.rdata = cmp_if.temp;
                default:                 next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign IO_RDATA         = s.rdata;
    assign PRESCALER_CLEAR  = s.psr_pulse;
    assign OSC_PINS_CLAIMED = s.as_mode;
    assign IRQ_TA_OVF = GLOBAL_IRQ_EN && s.irq_mask[TA_OVF_BIT]
                        && s.flags[TA_OVF_BIT];
    assign IRQ_TA_CMP = GLOBAL_IRQ_EN && s.irq_mask[TA_CMP_BIT]
                        && s.flags[TA_CMP_BIT];
    assign IRQ_TB_OVF = GLOBAL_IRQ_EN && s.irq_mask[TB_OVF_BIT]
                        && s.flags[TB_OVF_BIT];
    assign IRQ_TB_CMP = GLOBAL_IRQ_EN && s.irq_mask[TB_CMP_BIT]
                        && s.flags[TB_CMP_BIT];

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    psr_self_clear_a: assert property (
        psr_write |=> s.pre == PRESCALER_RESET && PRESCALER_CLEAR
                      ##1 (PRESCALER_CLEAR == $past(psr_write)))
        else $error("prescaler reset pulse wrong");

    psr_read_zero_a: assert property (
        (IO_RE && IO_ADDR == ADDR_SPECIAL_FUNCTION) |=> IO_RDATA == 8'h00)
        else $error("prescaler reset bit read nonzero");

    sequence ta_leave_zero;
        ta_tick && s.ta_ctrl[CTRL_UPDOWN_BIT] && s.ta_down
        && s.ta_cnt == COUNT_BOTTOM
        && !(IO_WE && IO_ADDR == ADDR_TIMER_A_COUNT);
    endsequence

    updown_ovf_a: assert property (
        ta_leave_zero |=> s.flags[TA_OVF_BIT] && s.ta_cnt == 8'h01)
        else $error("up/down overflow flag missing");

    wrap_ovf_a: assert property (
        (ta_tick && !s.ta_ctrl[CTRL_UPDOWN_BIT] && s.ta_cnt == COUNT_TOP
         && !IO_WE) |=> s.flags[TA_OVF_BIT] && s.ta_cnt == COUNT_BOTTOM)
        else $error("wrap overflow flag missing");

    irq_gate_a: assert property (
        $rose(IRQ_TB_OVF) |-> GLOBAL_IRQ_EN && s.irq_mask[TB_OVF_BIT]
                              && s.flags[TB_OVF_BIT])
        else $error("overflow interrupt not gated");

    cmp_flag_a: assert property (
        (ta_tick && s.ta_cnt == s.ta_cmp) |=> s.flags[TA_CMP_BIT])
        else $error("compare flag missing");

    sync_clock_a: assert property (
        !s.as_mode |-> tb_src_tick)
        else $error("timer b not on system clock");

    osc_clock_a: assert property (
        (s.as_mode && !$rose(s.osc_sync[1])) |-> !tb_src_tick)
        else $error("timer b ticked without oscillator edge");

    sequence tb_ovf_async;
        s.as_mode && step_b.ovf ##1 s.as_mode [*3];
    endsequence

    flag_delay_a: assert property (
        tb_ovf_async |=> s.flags[TB_OVF_BIT])
        else $error("async overflow flag not after sync delay");

    flag_early_a: assert property (
        (s.as_mode && step_b.ovf && !s.flags[TB_OVF_BIT]
         && s.evt_pipe == '0) ##1 s.as_mode |=> !s.flags[TB_OVF_BIT])
        else $error("async overflow flag too early");

    count_live_a: assert property (
        (IO_RE && IO_ADDR == ADDR_TIMER_B_COUNT)
        |=> IO_RDATA == $past(s.tb_cnt))
        else $error("count read not live value");

    cmp_temp_a: assert property (
        (IO_RE && IO_ADDR == ADDR_TIMER_B_COMPARE)
        |=> IO_RDATA == $past(cmp_if.temp))
        else $error("compare read not holding copy");

endmodule

// ===== verif/att_osc.sv
// crystal oscillator model driving the timer's oscillator pin
// assumes the bench gates it; the pin stands low while stopped
`timescale 1ns/100ps

module att_osc (
    input  wire logic run,
    output logic      osc
);
    // -------------------------------------------------------------------
    // 400 ns period, offset so edges never meet the system clock edge
    // -------------------------------------------------------------------
    initial begin
        osc = 1'b0;
        #7;
        forever #200 osc = run ? ~osc : 1'b0;
    end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the two-timer block and its staged registers
// assumes 20 MHz system clock and the oscillator model on the pin
`timescale 1ns/100ps

module tb_top;
    import att_pkg::*;
    logic       clk, rst, we, re, gie, run;
    logic [5:0] addr;
    logic [7:0] wdata, rdata;
    logic       osc, claimed, pclr, ta_ovf, ta_cmp, tb_ovf, tb_cmp;
    int         miscompares, tests_run, n;

    att_timer dut (.SYS_CLK(clk), .SYS_RST(rst), .IO_ADDR(addr),
        .IO_WDATA(wdata), .IO_WE(we), .IO_RE(re), .IO_RDATA(rdata),
        .GLOBAL_IRQ_EN(gie), .OSC_IN(osc), .OSC_PINS_CLAIMED(claimed),
        .PRESCALER_CLEAR(pclr), .IRQ_TA_OVF(ta_ovf), .IRQ_TA_CMP(ta_cmp),
        .IRQ_TB_OVF(tb_ovf), .IRQ_TB_CMP(tb_cmp));
    att_osc osc_model (.run(run), .osc(osc));

    always #25 clk = ~clk;

    // -------------------------------------------------------------------
    // access tasks
    // -------------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        tests_run++;
        if (rdata !== e) begin
            miscompares++;
            $display("[FAIL] %0t read %h got %h exp %h", $time, a, rdata, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t pin got %b exp %b", $time, g, e);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // watchdog: the sequence needs well under 200 us
    // -------------------------------------------------------------------
    initial begin
        #1ms;
        miscompares++;
        finish_test();
    end

    initial begin
        {clk, we, re, gie, run, addr, wdata} = '0;
        miscompares = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h00);
        rd(6'h3F, 8'h00);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        $display("test reset done");
        wr(ADDR_SPECIAL_FUNCTION, 8'h01);
        #1 chk1(pclr, 1'b1);
        @(posedge clk);
        #1 chk1(pclr, 1'b0);
        rd(ADDR_SPECIAL_FUNCTION, 8'h00);
        wr(ADDR_SPECIAL_FUNCTION, 8'h00);
        #1 chk1(pclr, 1'b0);
        $display("test prescaler done");
        // timer a on the /8 tap: wraps after two ticks, matches after six
        wr(ADDR_TIMER_A_COMPARE, 8'h03);
        wr(ADDR_TIMER_A_COUNT, 8'hFE);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'hFF);
        wr(ADDR_TIMER_IRQ_MASK, 8'h03);
        gie <= 1'b1;
        wr(ADDR_TIMER_A_CONTROL, 8'h02);
        repeat (60) @(posedge clk);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'h03);
        chk1(ta_ovf, 1'b1);
        chk1(ta_cmp, 1'b1);
        wr(ADDR_TIMER_A_CONTROL, 8'h00);
        gie <= 1'b0;
        $display("test timer a done");
        // overflow pwm counts as normal mode on the system clock
        wr(ADDR_TIMER_B_COMPARE, 8'h80);
        wr(ADDR_TIMER_B_COUNT, 8'hFD);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'hFF);
        wr(ADDR_TIMER_IRQ_MASK, 8'h40);
        gie <= 1'b1;
        wr(ADDR_TIMER_B_CONTROL, 8'h09);
        rd(ADDR_TIMER_B_CONTROL, 8'h09);
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h00);
        repeat (10) @(posedge clk);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'h40);
        chk1(tb_ovf, 1'b1);
        chk1(tb_cmp, 1'b0);
        gie <= 1'b0;
        @(posedge clk);
        #1 chk1(tb_ovf, 1'b0);
        repeat (150) @(posedge clk);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'hC0);
        wr(ADDR_TIMER_B_CONTROL, 8'h40);
        wr(ADDR_TIMER_B_COUNT, 8'h00);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'hFF);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        wr(ADDR_TIMER_B_CONTROL, 8'h41);
        repeat (5) @(posedge clk);
        rd(ADDR_TIMER_IRQ_FLAGS, 8'h40);
        wr(ADDR_TIMER_B_CONTROL, 8'h00);
        $display("test sync modes done");
        // oscillator held still so busy must stay up until it runs
        wr(ADDR_ASYNC_TIMER_STATUS, 8'h08);
        @(posedge clk);
        #1 chk1(claimed, 1'b1);
        wr(ADDR_TIMER_B_COUNT, 8'h55);
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h0C);
        wr(ADDR_TIMER_B_COMPARE, 8'h60);
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h0E);
        wr(ADDR_TIMER_B_CONTROL, 8'h01);
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h0F);
        rd(ADDR_TIMER_B_COMPARE, 8'h60);
        repeat (20) @(posedge clk);
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h0F);
        run <= 1'b1;
        n = 0;
        // software waits for all busy flags to drop before touching
        while (rdata !== 8'h08 && n < 100) begin
            @(posedge clk);
            addr <= ADDR_ASYNC_TIMER_STATUS;
            re <= 1'b1;
            @(posedge clk);
            re <= 1'b0;
            #1 n++;
            chk1(rdata[7:4] == 4'h0 && rdata[3], 1'b1);
        end
        chk1(n < 100, 1'b1);
        // oscillator left running so the live count moves past the staged one
        repeat (20) @(posedge clk);
        run <= 1'b0;
        rd(ADDR_ASYNC_TIMER_STATUS, 8'h08);
        @(posedge clk);
        addr <= ADDR_TIMER_B_COUNT;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 tests_run++;
        if (rdata < 8'h56 || rdata > 8'h59) begin
            miscompares++;
            $display("[FAIL] %0t live count %h", $time, rdata);
        end
        rd(ADDR_TIMER_B_CONTROL, 8'h01);
        $display("test async staging done");
        finish_test();
    end
endmodule
